// ---- rtl/tccd_top.sv ----
`timescale 1ns/10ps
module tccd_top #(
  parameter int NUM_DRIVES = tccd_pkg::MAX_DRIVES
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   cmdStrobe,
  input  wire logic [7:0]             cmdByte,
  input  wire logic [2:0]             cmdDrive,
  input  wire logic                   xferDone,
  input  wire logic                   statusAck,
  input  wire logic                   nrzi9Option,
  input  wire logic                   track7Option,
  input  wire logic                   translateOn,
  input  wire logic                   convertOn,
  input  wire logic                   densWrite,
  input  wire logic [2:0]             densDrive,
  input  wire logic [1:0]             densValue,
  input  wire logic                   chanValid,
  output logic                        chanReady,
  input  wire logic [7:0]             chanData,
  output logic                        chanOutValid,
  input  wire logic                   chanOutReady,
  output logic [7:0]                  chanOutData,
  input  wire logic                   tapeInValid,
  input  wire logic [5:0]             tapeInChar,
  output logic [NUM_DRIVES-1:0]       tapeOutValid,
  output logic [5:0]                  tapeOutChar,
  output logic [NUM_DRIVES-1:0]       drivePortSel,
  output tccd_pkg::tccd_cmd_s         cmdLatched,
  output tccd_pkg::tccd_status_s      status,
  output logic                        statusValid,
  output logic                        busy,
  output logic                        track7Enabled,
  output logic [2*NUM_DRIVES-1:0]     driveDensity
);
  initial begin
    if (NUM_DRIVES < 1 || NUM_DRIVES > tccd_pkg::MAX_DRIVES) begin
      $error("At most eight drives are served.");
    end
  end

  // ********************************************************************
  // Command decode.
  // ********************************************************************
  tccd_pkg::tccd_class_e decCls;
  logic                  decToTape;
  always_comb begin
    decToTape = 1'b0;
    case (cmdByte)
      tccd_pkg::CMD_WRITE, tccd_pkg::CMD_LOOP_WR: begin
        decCls    = tccd_pkg::CLS_XFER;
        decToTape = 1'b1;
      end
      tccd_pkg::CMD_READ, tccd_pkg::CMD_READ_BK: decCls = tccd_pkg::CLS_XFER;
      tccd_pkg::CMD_SENSE, tccd_pkg::CMD_SNS_RSV,
      tccd_pkg::CMD_SNS_REL: decCls = tccd_pkg::CLS_XFER;
      tccd_pkg::CMD_REQ_TIE: decCls = tccd_pkg::CLS_XFER;
      tccd_pkg::CMD_SET_DIAG: begin
        decCls    = tccd_pkg::CLS_XFER;
        decToTape = 1'b1;
      end
      tccd_pkg::CMD_REWIND, tccd_pkg::CMD_REW_UNL, tccd_pkg::CMD_ERASE,
      tccd_pkg::CMD_WR_FSB: decCls = tccd_pkg::CLS_MOTION;
      tccd_pkg::CMD_BSP_BLK, tccd_pkg::CMD_BSP_FILE, tccd_pkg::CMD_FSP_BLK,
      tccd_pkg::CMD_FSP_FILE,
      tccd_pkg::CMD_SEC_ERA: decCls = tccd_pkg::CLS_MOTION;
      tccd_pkg::CMD_NOP,
      tccd_pkg::CMD_DIAG_SET: decCls = tccd_pkg::CLS_NONMOT;
      default: decCls = tccd_pkg::CLS_NONE;
    endcase
  end

  // ********************************************************************
  // Command sequencing.
  // ********************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_STATUS} tccd_state_e;
  tccd_state_e state_reg;
  logic        accept;
  assign accept = cmdStrobe && state_reg == ST_IDLE;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= (decCls == tccd_pkg::CLS_XFER) ? ST_XFER : ST_STATUS;
          end
        end
        ST_XFER: if (xferDone) state_reg <= ST_STATUS;
        ST_STATUS: if (statusAck) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdLatched <= '{toTape: 1'b0, valid: 1'b0,
                      cls: tccd_pkg::CLS_NONE, code: tccd_pkg::CMD_RESET};
      drivePortSel <= '0;
    end else if (accept) begin
      cmdLatched <= '{toTape: decToTape, valid: decCls != tccd_pkg::CLS_NONE,
                      cls: decCls, code: cmdByte};
      drivePortSel <= NUM_DRIVES'(1) << cmdDrive;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status      <= '0;
      statusValid <= 1'b0;
      busy        <= 1'b0;
    end else begin
      busy <= (state_reg != ST_IDLE) || accept;
      if (state_reg == ST_XFER && xferDone) begin
        status      <= '{channelEnd: 1'b1, deviceEnd: 1'b1,
                         unitCheck: 1'b0, cmdReject: 1'b0};
        statusValid <= 1'b1;
      end else if (accept && decCls != tccd_pkg::CLS_XFER) begin
        status      <= '{channelEnd: 1'b1, deviceEnd: 1'b1,
                         unitCheck: decCls == tccd_pkg::CLS_NONE,
                         cmdReject: decCls == tccd_pkg::CLS_NONE};
        statusValid <= 1'b1;
      end else if (state_reg == ST_STATUS && statusAck) begin
        statusValid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Configuration.
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      track7Enabled <= 1'b0;
    end else begin
      track7Enabled <= track7Option && nrzi9Option;
    end
  end

  for (genvar d = 0; d < NUM_DRIVES; d++) begin : g_dens
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        driveDensity[2*d +: 2] <= tccd_pkg::DENS_RESET;
      end else if (densWrite && densDrive == 3'(d)) begin
        driveDensity[2*d +: 2] <= densValue;
      end
    end
  end

  // ********************************************************************
  // Character translation.
  // ********************************************************************
  function automatic logic [5:0] toBcd(input logic [7:0] b);
    toBcd = {b[5:4], b[3:0]};
  endfunction
  function automatic logic [7:0] fromBcd(input logic [5:0] c);
    fromBcd = {2'h3, c};
  endfunction

  // ********************************************************************
  // Write path.
  // ********************************************************************
  logic       xferActive;
  logic       wfValid;
  logic       wfReady;
  logic [7:0] wfData;
  logic       wrHold;
  logic [1:0] wrPhase_reg;
  logic [7:0] wrCarry_reg;
  logic [5:0] wrChar;
  logic       wrTake;

  logic       wfInReady;

  assign xferActive = state_reg == ST_XFER;
  assign chanReady  = wfInReady && xferActive && cmdLatched.toTape;
  tccd_fifo #(.WIDTH(8), .DEPTH(tccd_pkg::FIFO_DEPTH)) u_wfifo (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .inValid (chanValid && xferActive && cmdLatched.toTape),
    .inReady (wfInReady),
    .inData  (chanData),
    .outValid(wfValid),
    .outReady(wfReady),
    .outData (wfData)
  );

  // The converter spends a fourth phase on the carried bits only.
  assign wrHold = convertOn && track7Enabled && wrPhase_reg == 2'h3;
  assign wfReady = !wrHold;
  assign wrTake  = wfValid && wfReady;

  always_comb begin
    if (!(convertOn && track7Enabled)) begin
      wrChar = translateOn ? toBcd(wfData) : wfData[5:0];
    end else begin
      case (wrPhase_reg)
        2'h0: wrChar = wfData[7:2];
        2'h1: wrChar = {wrCarry_reg[1:0], wfData[7:4]};
        2'h2: wrChar = {wrCarry_reg[3:0], wfData[7:6]};
        default: wrChar = wrCarry_reg[5:0];
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !xferActive) begin
      wrPhase_reg <= '0;
      wrCarry_reg <= '0;
    end else if (convertOn && track7Enabled && (wrTake || wrHold)) begin
      wrCarry_reg <= wfData;
      wrPhase_reg <= (wrPhase_reg == tccd_pkg::RATE_PHASES) ? 2'h0
                                                           : wrPhase_reg + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tapeOutValid <= '0;
      tapeOutChar  <= '0;
    end else begin
      tapeOutValid <= (wrTake || wrHold) ? drivePortSel : '0;
      tapeOutChar  <= wrChar;
    end
  end

  // ********************************************************************
  // Read path.
  // ********************************************************************
  logic [1:0] rdPhase_reg;
  logic [5:0] rdCarry_reg;
  logic       rdPush;
  logic [7:0] rdByte;
  logic       tapeInS1_reg;
  logic       tapeInS2_reg;
  logic [5:0] charS1_reg;
  logic [5:0] charS2_reg;
  logic       tapeInPrev_reg;
  logic       tapeInEvt;

  always_ff @(posedge mclk) begin
    tapeInS1_reg <= tapeInValid;
    tapeInS2_reg <= tapeInS1_reg;
    charS1_reg   <= tapeInChar;
    charS2_reg   <= charS1_reg;
    tapeInPrev_reg <= sys_rst ? 1'b0 : tapeInS2_reg;
  end
  assign tapeInEvt = tapeInS2_reg && !tapeInPrev_reg && xferActive
                     && !cmdLatched.toTape;

  always_comb begin
    rdPush = 1'b0;
    rdByte = '0;
    if (tapeInEvt) begin
      if (!(convertOn && track7Enabled)) begin
        rdPush = 1'b1;
        rdByte = translateOn ? fromBcd(charS2_reg) : {2'h0, charS2_reg};
      end else begin
        rdPush = rdPhase_reg != 2'h0;
        case (rdPhase_reg)
          2'h1: rdByte = {rdCarry_reg, charS2_reg[5:4]};
          2'h2: rdByte = {rdCarry_reg[3:0], charS2_reg[5:2]};
          2'h3: rdByte = {rdCarry_reg[1:0], charS2_reg};
          default: rdByte = '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !xferActive) begin
      rdPhase_reg <= '0;
      rdCarry_reg <= '0;
    end else if (tapeInEvt && convertOn && track7Enabled) begin
      rdCarry_reg <= charS2_reg;
      rdPhase_reg <= rdPhase_reg + 2'h1;
    end
  end

  logic       rfValid;
  logic [7:0] rfData;
  tccd_fifo #(.WIDTH(8), .DEPTH(tccd_pkg::FIFO_DEPTH)) u_rfifo (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .inValid (rdPush),
    .inReady (),
    .inData  (rdByte),
    .outValid(rfValid),
    .outReady(!chanOutValid || chanOutReady),
    .outData (rfData)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chanOutValid <= 1'b0;
      chanOutData  <= '0;
    end else if (!chanOutValid || chanOutReady) begin
      chanOutValid <= rfValid;
      chanOutData  <= rfData;
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  property p_reject;
    @(posedge mclk) disable iff (sys_rst)
    accept && decCls == tccd_pkg::CLS_NONE |=> status.cmdReject;
  endproperty
  a_reject: assert property (p_reject) else $error("Reject missed.");

  property p_end;
    @(posedge mclk) disable iff (sys_rst)
    state_reg == ST_XFER && xferDone |=> statusValid && status.channelEnd
      && status.deviceEnd;
  endproperty
  a_end: assert property (p_end) else $error("Ending status wrong.");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
    state_reg != ST_IDLE |=> $stable(cmdLatched);
  endproperty
  a_hold: assert property (p_hold) else $error("Command changed.");

  property p_nodata;
    @(posedge mclk) disable iff (sys_rst)
    cmdLatched.cls != tccd_pkg::CLS_XFER |-> !rdPush && !chanReady;
  endproperty
  a_nodata: assert property (p_nodata) else $error("Data moved.");

  property p_dep;
    @(posedge mclk) disable iff (sys_rst)
    !nrzi9Option |=> !track7Enabled;
  endproperty
  a_dep: assert property (p_dep) else $error("Option dependency.");

  property p_rate;
    @(posedge mclk) disable iff (sys_rst)
    convertOn && track7Enabled && xferActive && !xferDone && wrTake
      && wrPhase_reg == 2'h2 |=> wrHold && !wrTake;
  endproperty
  a_rate: assert property (p_rate) else $error("Rate not reduced.");

  property p_write;
    @(posedge mclk) disable iff (sys_rst)
    accept && cmdByte == tccd_pkg::CMD_WRITE |=> state_reg == ST_XFER;
  endproperty
  a_write: assert property (p_write) else $error("Write not data.");

  property p_motion;
    @(posedge mclk) disable iff (sys_rst)
    accept && cmdByte == tccd_pkg::CMD_REWIND |=>
      cmdLatched.cls == tccd_pkg::CLS_MOTION;
  endproperty
  a_motion: assert property (p_motion) else $error("Motion decode.");

  property p_busy;
    @(posedge mclk) disable iff (sys_rst)
    accept |=> busy && cmdLatched.code == $past(cmdByte);
  endproperty
  a_busy: assert property (p_busy) else $error("Command not latched.");

  property p_port;
    @(posedge mclk) disable iff (sys_rst)
    accept |=> drivePortSel == NUM_DRIVES'(1) << $past(cmdDrive);
  endproperty
  a_port: assert property (p_port) else $error("Port select wrong.");
endmodule // tccd_top

// ---- rtl/tccd_pkg.sv ----
// Function
// - Decode write 01, read 02, backward 0C.
// - Decode sense 04, reserve F4, release D4.
// - Decode 1B, 8B, 4B as data transfer.
// - Decode motion 07, 0F, 17, 1F.
// - Decode motion 27, 2F, 37, 3F, 97.
// - Decode 03 and 0B as non-motion.
// - Unknown code sets command rejected.
// - Only data transfer commands move bytes.
// - Data transfer ends with CE and DE.
// - At most eight drives, one port each.
// - Translator maps channel byte to BCD.
// - Translator maps BCD to channel byte.
// - Translator keeps rate and drive operation.
// - Converter packs three bytes into four.
// - Converter unpacks four characters into three.
// - Converter channel rate is 75 percent.
// - Seven-track densities 800, 556, 200.
// - Seven-track needs nine-track NRZI option.
// - Separate density per nine-track drive.
// - No interlock on write after read.
package tccd_pkg;

  localparam logic [7:0] CMD_WRITE    = 8'h01;
  localparam logic [7:0] CMD_READ     = 8'h02;
  localparam logic [7:0] CMD_READ_BK  = 8'h0C;
  localparam logic [7:0] CMD_SENSE    = 8'h04;
  localparam logic [7:0] CMD_SNS_RSV  = 8'hF4;
  localparam logic [7:0] CMD_SNS_REL  = 8'hD4;
  localparam logic [7:0] CMD_REQ_TIE  = 8'h1B;
  localparam logic [7:0] CMD_LOOP_WR  = 8'h8B;
  localparam logic [7:0] CMD_SET_DIAG = 8'h4B;
  localparam logic [7:0] CMD_REWIND   = 8'h07;
  localparam logic [7:0] CMD_REW_UNL  = 8'h0F;
  localparam logic [7:0] CMD_ERASE    = 8'h17;
  localparam logic [7:0] CMD_WR_FSB   = 8'h1F;
  localparam logic [7:0] CMD_BSP_BLK  = 8'h27;
  localparam logic [7:0] CMD_BSP_FILE = 8'h2F;
  localparam logic [7:0] CMD_FSP_BLK  = 8'h37;
  localparam logic [7:0] CMD_FSP_FILE = 8'h3F;
  localparam logic [7:0] CMD_SEC_ERA  = 8'h97;
  localparam logic [7:0] CMD_NOP      = 8'h03;
  localparam logic [7:0] CMD_DIAG_SET = 8'h0B;

  localparam int          MAX_DRIVES  = 8;
  localparam int          FIFO_DEPTH  = 32;
  localparam logic [1:0]  RATE_PHASES = 2'h3;
  localparam logic [1:0]  DENS_RESET  = 2'h0;
  localparam logic [7:0]  CMD_RESET   = 8'h03;

  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_XFER,
    CLS_MOTION,
    CLS_NONMOT
  } tccd_class_e;

  typedef enum logic [1:0] {
    DEN_800,
    DEN_556,
    DEN_200,
    DEN_1600
  } tccd_dens_e;

  typedef struct packed {
    logic        toTape;
    logic        valid;
    tccd_class_e cls;
    logic [7:0]  code;
  } tccd_cmd_s;

  typedef struct packed {
    logic channelEnd;
    logic deviceEnd;
    logic unitCheck;
    logic cmdReject;
  } tccd_status_s;

endpackage

// ---- rtl/tccd_fifo.sv ----
`timescale 1ns/10ps
module tccd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("Depth must be a power of two.");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic             doWr;
  logic             doRd;

  assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData  = mem[rdPtr_reg[AW-1:0]];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
    end else if (doWr) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdPtr_reg <= '0;
    end else if (doRd) begin
      rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule // tccd_fifo

// ---- tb/tccd_chan_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Channel side model that issues commands and takes status.
// ****************************************************************
module tccd_chan_model (
  input  wire logic       mclk,
  input  wire logic       busy,
  output logic            cmdStrobe,
  output logic [7:0]      cmdByte,
  output logic [2:0]      cmdDrive,
  output logic            xferDone,
  output logic            statusAck
);
  logic fwdRead;

  initial begin
    cmdStrobe = 1'b0;
    cmdByte   = 8'h00;
    cmdDrive  = 3'h0;
    xferDone  = 1'b0;
    statusAck = 1'b0;
    fwdRead   = 1'b0;
  end

  // ****************************************************************
  // Command issue, data end and status acceptance.
  // ****************************************************************
  task automatic issue(input logic [7:0] code, input logic [2:0] drv,
                       input logic tmKnown);
    int n;
    n = 0;
    if (fwdRead && !tmKnown
        && (code == 8'h01 || code == 8'h1F || code == 8'h17)) begin
      return;
    end
    while (busy !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    cmdStrobe = 1'b1;
    cmdByte   = code;
    cmdDrive  = drv;
    @(negedge mclk);
    cmdStrobe = 1'b0;
    cmdByte   = ~code;
    cmdDrive  = ~drv;
    fwdRead   = (code == 8'h02 || code == 8'h37 || code == 8'h3F);
  endtask

  task automatic finish();
    @(negedge mclk);
    xferDone = 1'b1;
    @(negedge mclk);
    xferDone = 1'b0;
  endtask

  task automatic ack(input int slow);
    repeat (slow) @(negedge mclk);
    statusAck = 1'b1;
    @(negedge mclk);
    statusAck = 1'b0;
  endtask
endmodule // tccd_chan_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic                   mclk, sys_rst, xferDone, statusAck;
  logic                   cmdStrobe, nrzi9Option, track7Option;
  logic                   translateOn, convertOn, densWrite;
  logic                   chanValid, chanReady, chanOutValid;
  logic                   chanOutReady, tapeInValid, statusValid;
  logic                   busy, track7Enabled;
  logic [7:0]             cmdByte, chanData, chanOutData;
  logic [7:0]             tapeOutValid, drivePortSel, lastPort;
  logic [2:0]             cmdDrive, densDrive;
  logic [1:0]             densValue;
  logic [5:0]             tapeInChar, tapeOutChar;
  logic [15:0]            driveDensity;
  tccd_pkg::tccd_cmd_s    cmdLatched;
  tccd_pkg::tccd_status_s status;
  logic [5:0]             charQ[$];
  logic [7:0]             byteQ[$];
  int                     bad_count, compares;
  localparam logic [7:0] CODES [20] = '{8'h01, 8'h02, 8'h0C, 8'h04, 8'hF4,
    8'hD4, 8'h1B, 8'h8B, 8'h4B, 8'h07, 8'h0F, 8'h17, 8'h1F, 8'h27, 8'h2F,
    8'h37, 8'h3F, 8'h97, 8'h03, 8'h0B};

  tccd_top uut (.mclk(mclk), .sys_rst(sys_rst), .cmdStrobe(cmdStrobe),
    .cmdByte(cmdByte), .cmdDrive(cmdDrive), .xferDone(xferDone),
    .statusAck(statusAck), .nrzi9Option(nrzi9Option),
    .track7Option(track7Option), .translateOn(translateOn),
    .convertOn(convertOn), .densWrite(densWrite), .densDrive(densDrive),
    .densValue(densValue), .chanValid(chanValid), .chanReady(chanReady),
    .chanData(chanData), .chanOutValid(chanOutValid),
    .chanOutReady(chanOutReady), .chanOutData(chanOutData),
    .tapeInValid(tapeInValid), .tapeInChar(tapeInChar),
    .tapeOutValid(tapeOutValid), .tapeOutChar(tapeOutChar),
    .drivePortSel(drivePortSel), .cmdLatched(cmdLatched), .status(status),
    .statusValid(statusValid), .busy(busy), .track7Enabled(track7Enabled),
    .driveDensity(driveDensity));

  tccd_chan_model chan (.mclk(mclk), .busy(busy), .cmdStrobe(cmdStrobe),
    .cmdByte(cmdByte), .cmdDrive(cmdDrive), .xferDone(xferDone),
    .statusAck(statusAck));

  // ****************************************************************
  // Clock, monitors and shared tasks.
  // ****************************************************************
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (tapeOutValid != 8'h00) begin
      charQ.push_back(tapeOutChar);
      lastPort = tapeOutValid;
    end
    if ((chanOutValid & chanOutReady) === 1'b1) byteQ.push_back(chanOutData);
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_status(input logic [3:0] exp);
    int n;
    n = 0;
    while (statusValid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("statusValid", 32'h1, 32'(statusValid));
    chk("status", 32'(exp), 32'(status));
  endtask

  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge mclk);
    chanValid = 1'b1;
    chanData  = b;
    @(posedge mclk);
    while (chanReady !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    @(negedge mclk);
    chanValid = 1'b0;
    chanData  = ~b;
    chk("byteTaken", 32'h1, 32'(n < 60));
  endtask

  task automatic tape_char(input logic [5:0] c);
    tapeInChar  = c;
    tapeInValid = 1'b1;
    repeat (4) @(negedge mclk);
    tapeInValid = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  task automatic wait_queue(input int want);
    int n;
    n = 0;
    while (charQ.size() + byteQ.size() < want && n < 300) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic close_cmd(input int slow);
    chan.finish();
    wait_status(4'hC);
    chan.ack(slow);
    charQ.delete();
    byteQ.delete();
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    chk("busy", 32'h0, 32'(busy));
    chk("statusValid", 32'h0, 32'(statusValid));
    chk("code", 32'h03, 32'(cmdLatched.code));
    chk("density", 32'h0, 32'(driveDensity));
    chk("track7", 32'h0, 32'(track7Enabled));
  endtask

  task automatic t_classify();
    logic [7:0] c;
    for (int i = 0; i < 20; i++) begin
      c = CODES[i];
      chan.issue(c, 3'h2, 1'b0);
      chk("code", 32'(c), 32'(cmdLatched.code));
      chk("valid", 32'h1, 32'(cmdLatched.valid));
      if (i < 9) begin
        chk("cls", 32'(tccd_pkg::CLS_XFER), 32'(cmdLatched.cls));
        chk("toTape", 32'(c == 8'h01 || c[3:0] == 4'hB && c[7]^c[6]),
            32'(cmdLatched.toTape));
        chk("early", 32'h0, 32'(statusValid));
        chan.finish();
      end else begin
        chk("cls", 32'(i < 18 ? tccd_pkg::CLS_MOTION : tccd_pkg::CLS_NONMOT),
            32'(cmdLatched.cls));
      end
      wait_status(4'hC);
      chk("held", 32'(c), 32'(cmdLatched.code));
      chan.ack(i % 3);
    end
  endtask

  task automatic t_reject();
    logic [7:0] bad [4] = '{8'h00, 8'hFF, 8'h05, 8'h8C};
    for (int i = 0; i < 4; i++) begin
      chan.issue(bad[i], 3'h0, 1'b0);
      wait_status(4'hF);
      chk("valid", 32'h0, 32'(cmdLatched.valid));
      chk("noData", 32'h0, 32'(chanReady));
      chan.ack(1);
    end
  endtask

  task automatic t_nodata();
    chan.issue(8'h07, 3'h4, 1'b0);
    chanValid = 1'b1;
    repeat (4) begin
      @(negedge mclk);
      chk("chanReady", 32'h0, 32'(chanReady));
    end
    chanValid = 1'b0;
    chk("tapeOut", 32'h0, 32'(charQ.size()));
    wait_status(4'hC);
    chan.ack(0);
  endtask

  task automatic t_write_xlate();
    logic [7:0] b [3] = '{8'hC1, 8'hF5, 8'h3A};
    translateOn = 1'b1;
    chan.issue(8'h01, 3'h5, 1'b0);
    chk("portSel", 32'h20, 32'(drivePortSel));
    for (int i = 0; i < 3; i++) send_byte(b[i]);
    wait_queue(3);
    chk("count", 32'h3, 32'(charQ.size()));
    for (int i = 0; i < 3; i++) begin
      chk("char", 32'(b[i][5:0]), 32'(charQ[i]));
    end
    chk("port", 32'h20, 32'(lastPort));
    close_cmd(2);
  endtask

  task automatic t_read_xlate();
    chan.issue(8'h02, 3'h1, 1'b0);
    chanOutReady = 1'b0;
    tape_char(6'h05);
    tape_char(6'h21);
    chanOutReady = 1'b1;
    wait_queue(2);
    chk("rdCount", 32'h2, 32'(byteQ.size()));
    chk("rd0", 32'hC5, 32'(byteQ[0]));
    chk("rd1", 32'hE1, 32'(byteQ[1]));
    close_cmd(0);
  endtask

  task automatic t_convert();
    logic [23:0] w;
    translateOn  = 1'b0;
    track7Option = 1'b1;
    repeat (3) @(negedge mclk);
    chk("track7", 32'h0, 32'(track7Enabled));
    nrzi9Option = 1'b1;
    convertOn   = 1'b1;
    repeat (3) @(negedge mclk);
    chk("track7", 32'h1, 32'(track7Enabled));
    w = 24'hA53C96;
    chan.issue(8'h01, 3'h0, 1'b1);
    for (int i = 2; i >= 0; i--) send_byte(w[8*i +: 8]);
    wait_queue(4);
    chk("cvCount", 32'h4, 32'(charQ.size()));
    for (int i = 0; i < 4; i++) begin
      chk("cvChar", 32'(w[18-6*i +: 6]), 32'(charQ[i]));
    end
    close_cmd(1);
    chan.issue(8'h02, 3'h0, 1'b1);
    for (int i = 0; i < 4; i++) tape_char(w[18-6*i +: 6]);
    wait_queue(3);
    chk("unCount", 32'h3, 32'(byteQ.size()));
    for (int i = 0; i < 3; i++) begin
      chk("unByte", 32'(w[16-8*i +: 8]), 32'(byteQ[i]));
    end
    close_cmd(0);
    convertOn = 1'b0;
  endtask

  task automatic t_density();
    for (int d = 0; d < 8; d++) begin
      densWrite = 1'b1;
      densDrive = 3'(d);
      densValue = 2'(d);
      @(negedge mclk);
      densWrite = 1'b0;
      @(negedge mclk);
    end
    chk("density", 32'hE4E4, 32'(driveDensity));
  endtask

  task automatic t_write_after_read();
    chan.issue(8'h02, 3'h3, 1'b0);
    tape_char(6'h11);
    close_cmd(0);
    chan.issue(8'h01, 3'h3, 1'b1);
    chk("accepted", 32'h01, 32'(cmdLatched.code));
    chk("busy", 32'h1, 32'(busy));
    send_byte(8'h2D);
    wait_queue(1);
    chk("written", 32'h1, 32'(charQ.size()));
    close_cmd(0);
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    nrzi9Option = 1'b0;
    track7Option = 1'b0;
    translateOn = 1'b0;
    convertOn = 1'b0;
    densWrite = 1'b0;
    densDrive = 3'h0;
    densValue = 2'h0;
    chanValid = 1'b0;
    chanData = 8'h00;
    chanOutReady = 1'b1;
    tapeInValid = 1'b0;
    tapeInChar = 6'h00;
    lastPort = 8'h00;
    bad_count = 0;
    compares = 0;
    repeat (10) @(negedge mclk);
    t_reset();
    sys_rst = 1'b0;
    @(negedge mclk);
    t_classify();
    t_reject();
    t_nodata();
    t_write_xlate();
    t_read_xlate();
    t_convert();
    t_density();
    t_write_after_read();
    report_and_stop();
  end

  initial begin
    #800000;
    bad_count++;
    report_and_stop();
  end
endmodule // tb
